// file: hdl/sfcd_frame_decoder.sv
// serial frame handler and 32-bit command decoder
//
// Function
// - frame opens on select fall, closes on next rise, which starts conversion
// - select fall drives ready strobe low
// - select fall clears the capture edge counter
// - frame open drives output lane and loads 32-bit output word
// - frame open clears the command register to zero, a no-op
// - each capture edge counts and shifts input bit into LSB
// - each launch edge presents next output MSB on the lane
// - select rise releases the output lane
// - select rise hands input word to decoding; writes act then
// - ready stays low during conversion, rises when conversion finishes
// - exactly 32 capture edges makes an optimal, valid command frame
// - fewer than 32 edges means no write; shifted output stays valid
// - long frames unlimited; last 32 bits before closing are decoded
// - 9-bit address is zero plus byte address; half-word ignores LSB
// - all-zero word and undefined opcodes do nothing
// - prefix 11000 clears register bits where data bit is one
// - prefix 11011 sets register bits where data bit is one
// - prefix 11001 with zero data returns 16 register bits next frame
// - prefix 01001 with zero data returns eight register bits next frame
// - prefix 11010 sub-code 00 writes both bytes of half-word
// - sub-code 01 writes MS byte only, 10 writes LS byte only
// - after reset, capture on rising clock edge with clock idle low
// - without read or fixed pattern, output word holds conversion result
`timescale 1ns/1ns
`include "sfcd_regs.svh"

module sfcd_frame_decoder (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // serial pins from the host
   input wire logic conversion_start_select_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   // serial output lane, enable active low
   output logic serial_output_lanes_o,
   output logic serial_output_lanes_oe_n_o,
   output logic ready_strobe_o,
   // converter core
   output logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic [15:0] conv_result_i,
   // fixed output pattern option
   input wire logic fixed_pattern_en_i,
   input wire logic [`SFCD_CMD_W-1:0] fixed_pattern_i,
   // decoded command and register map
   output logic [`SFCD_CMD_W-1:0] cmd_word_o,
   output logic [`SFCD_HW_COUNT*16-1:0] reg_map_o
);

   // reset image of the whole state
   localparam sfcd_pkg::sfcd_state_t S_RST = '{
      st: sfcd_pkg::ST_ACQ,
      rdy: 1'b1,
      drv: 1'b0,
      conv_start: 1'b0,
      cs_q: 1'b0, // same level as the synchroniser's reset, so no false select edge
      sclk_q: 1'b0,
      cnt: `SFCD_CNT_ZERO,
      isr: `SFCD_CMD_RST,
      output_shift_register: `SFCD_CMD_RST,
      cmd: `SFCD_CMD_RST,
      rd_pend: sfcd_pkg::RD_NONE,
      rd_word: `SFCD_CMD_RST,
      regs: '0
   };

   sfcd_pkg::sfcd_state_t s_r;
   sfcd_pkg::sfcd_state_t s_nxt;
   sfcd_pkg::sfcd_pins_t pins_raw;
   sfcd_pkg::sfcd_pins_t pins;

   // pins come from the host's domain, so two flops before any use
   assign pins_raw = '{
      cs: conversion_start_select_i,
      sclk: sclk_i,
      sdi: sdi_i
   };

   sfcd_sync #(
      .W(3)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .async_i(pins_raw),
      .sync_o(pins)
   );

   // edges of the synchronised pins
   logic cs_fall;
   logic cs_rise;
   logic cap_edge;
   logic launch_edge;

   // fixed mode: clock idles low, capture rising, launch falling
   assign cs_fall = s_r.cs_q & ~pins.cs;
   assign cs_rise = ~s_r.cs_q & pins.cs;
   assign cap_edge = ~s_r.sclk_q & pins.sclk;
   assign launch_edge = s_r.sclk_q & ~pins.sclk;

   // output word for the frame about to open
   function automatic logic [`SFCD_CMD_W-1:0] pick_word(
      input logic fixed_en,
      input logic [`SFCD_CMD_W-1:0] fixed_word,
      input sfcd_pkg::sfcd_rd_t pend,
      input logic [`SFCD_CMD_W-1:0] rd_word,
      input logic [15:0] result
   );
      logic [`SFCD_CMD_W-1:0] w;
      // result left-aligned, zeros behind it
      w = {result, 16'h0000};
      // the fixed pattern outranks a pending read
      if (fixed_en) begin
         w = fixed_word;
      end else if (pend != sfcd_pkg::RD_NONE) begin
         w = rd_word;
      end
      return w;
   endfunction : pick_word

   // command field views of the received word
   logic [4:0] op;
   logic [1:0] sub;
   logic [8:0] addr;
   logic [15:0] data;
   logic [`SFCD_IDX_W-1:0] idx;
   logic in_map;
   logic [15:0] hw;

   // views taken straight off the input shifter
   assign op = s_r.isr[`SFCD_OP_HI:`SFCD_OP_LO];
   assign sub = s_r.isr[`SFCD_SUB_HI:`SFCD_SUB_LO];
   assign addr = s_r.isr[`SFCD_ADDR_HI:`SFCD_ADDR_LO];
   assign data = s_r.isr[`SFCD_DATA_HI:`SFCD_DATA_LO];
   // half-word index drops the address LSB
   assign idx = addr[`SFCD_IDX_HI:`SFCD_IDX_LO];
   // address bits 8 to 5 must be zero; higher bytes are outside the map
   assign in_map = (addr[`SFCD_SPAN_HI:`SFCD_SPAN_LO] == 4'h0);
   // current contents of the addressed half-word
   assign hw = s_r.regs[idx];

   // optimal or long frame: the shifter holds a whole command
   logic full_frame;
   assign full_frame = (s_r.cnt >= `SFCD_CNT_OPT);

   // next-state logic for the frame sequencer and decoder
   always_comb begin
      s_nxt = s_r;
      // start strobe lasts a single cycle
      s_nxt.conv_start = 1'b0;
      // pin history for the edge detectors
      s_nxt.cs_q = pins.cs;
      s_nxt.sclk_q = pins.sclk;

      case (s_r.st)
         sfcd_pkg::ST_ACQ: begin
            // sclk edges before the frame opens are ignored
            // frame opens on select fall
            if (cs_fall) begin
               s_nxt.st = sfcd_pkg::ST_FRAME;
               s_nxt.rdy = 1'b0;
               s_nxt.cnt = `SFCD_CNT_ZERO;
               // take the lane, load output word
               s_nxt.drv = 1'b1;
               // conversion result unless read or pattern
               s_nxt.output_shift_register = pick_word(fixed_pattern_en_i, fixed_pattern_i,
                                     s_r.rd_pend, s_r.rd_word, conv_result_i);
               // a latched read serves this one frame only
               s_nxt.rd_pend = sfcd_pkg::RD_NONE;
               s_nxt.cmd = `SFCD_CMD_RST;
            end
         end

         sfcd_pkg::ST_FRAME: begin
            // frame closes on select rise, conversion begins
            if (cs_rise) begin
               s_nxt.st = sfcd_pkg::ST_CONV;
               s_nxt.conv_start = 1'b1;
               s_nxt.rdy = 1'b0;
               s_nxt.drv = 1'b0;
               // optimal frame gives a valid word
               // short frame: no write, no read latch
               // long frame: last 32 bits stand in the shifter
               if (full_frame) begin
                  // word handed to decoding on the closing edge
                  s_nxt.cmd = s_r.isr;
                  // unknown opcodes fall through as no-op
                  // effects only for optimal or long frames
                  // addresses past the map are dropped, never wrapped
                  if (in_map) begin
                     case (op)
                        // clear where data bit is one
                        `SFCD_OP_CLEAR: begin
                           s_nxt.regs[idx] = hw & ~data;
                        end
                        // set where data bit is one
                        `SFCD_OP_SET: begin
                           s_nxt.regs[idx] = hw | data;
                        end
                        `SFCD_OP_WRITE: begin
                           case (sub)
                              `SFCD_SUB_BOTH: begin
                                 s_nxt.regs[idx] = data;
                              end
                              `SFCD_SUB_MS_BYTE: begin
                                 s_nxt.regs[idx] = {data[15:8], hw[7:0]};
                              end
                              `SFCD_SUB_LS_BYTE: begin
                                 s_nxt.regs[idx] = {hw[15:8], data[7:0]};
                              end
                              default: begin
                                 // sub-code 11 is undefined: no change
                                 s_nxt.regs[idx] = hw;
                              end
                           endcase
                        end
                        // half-word read latched for next frame
                        `SFCD_OP_READ_HALF: begin
                           if (data == 16'h0000) begin
                              s_nxt.rd_pend = sfcd_pkg::RD_HALF;
                              s_nxt.rd_word = {hw, 16'h0000};
                           end
                        end
                        // byte read keeps the exact byte address
                        `SFCD_OP_READ_BYTE: begin
                           if (data == 16'h0000) begin
                              s_nxt.rd_pend = sfcd_pkg::RD_BYTE;
                              s_nxt.rd_word = addr[0] ? {hw[15:8], 24'h00_0000}
                                                      : {hw[7:0], 24'h00_0000};
                           end
                        end
                        default: begin
                           // no-op opcodes leave the map alone
                           s_nxt.regs[idx] = hw;
                        end
                     endcase
                  end
               end
            end else begin
               // capture edge: count and shift in
               if (cap_edge) begin
                  // saturate so a very long frame still counts as long
                  if (s_r.cnt != `SFCD_CNT_MAX) begin
                     s_nxt.cnt = s_r.cnt + `SFCD_CNT_ONE;
                  end
                  // only the newest 32 bits survive
                  s_nxt.isr = {s_r.isr[`SFCD_CMD_W-2:0], pins.sdi};
               end
               // launch edge: next bit to the lane MSB first
               if (launch_edge) begin
                  // zeros fill behind, so extra launch edges show zeros
                  s_nxt.output_shift_register = {s_r.output_shift_register[`SFCD_CMD_W-2:0], 1'b0};
               end
            end
         end

         sfcd_pkg::ST_CONV: begin
            // select changes are ignored until the converter is done
            // ready rises when conversion finishes
            if (conv_done_i) begin
               s_nxt.st = sfcd_pkg::ST_ACQ;
               s_nxt.rdy = 1'b1;
            end
         end

         default: begin
            // a broken state code falls back to the reset image
            s_nxt = S_RST;
         end
      endcase
   end

   // single state register
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from state flops
   assign serial_output_lanes_o = s_r.output_shift_register[`SFCD_CMD_W-1];
   assign serial_output_lanes_oe_n_o = ~s_r.drv; // low while driving
   assign ready_strobe_o = s_r.rdy;
   assign conv_start_o = s_r.conv_start;

   // command and map move only at frame open or close
   assign cmd_word_o = s_r.cmd;
   assign reg_map_o = s_r.regs;

endmodule : sfcd_frame_decoder

// file: include/sfcd_regs.svh
// constants for the serial frame command decoder
`ifndef SFCD_REGS_SVH
`define SFCD_REGS_SVH

// command word layout
`define SFCD_CMD_W 32
`define SFCD_OP_HI 31
`define SFCD_OP_LO 27
`define SFCD_SUB_HI 26
`define SFCD_SUB_LO 25
`define SFCD_ADDR_HI 24
`define SFCD_ADDR_LO 16
`define SFCD_DATA_HI 15
`define SFCD_DATA_LO 0

// opcode prefixes
`define SFCD_OP_CLEAR 5'h18
`define SFCD_OP_READ_HALF 5'h19
`define SFCD_OP_WRITE 5'h1a
`define SFCD_OP_SET 5'h1b
`define SFCD_OP_READ_BYTE 5'h09

// write sub-codes
`define SFCD_SUB_BOTH 2'h0
`define SFCD_SUB_MS_BYTE 2'h1
`define SFCD_SUB_LS_BYTE 2'h2

// register map: 16 half-words, byte addresses 00h..1fh
`define SFCD_HW_COUNT 16
`define SFCD_IDX_W 4
`define SFCD_IDX_HI 4
`define SFCD_IDX_LO 1
`define SFCD_SPAN_HI 8
`define SFCD_SPAN_LO 5

// edge counter
`define SFCD_CNT_W 6
`define SFCD_CNT_ZERO 6'h00
`define SFCD_CNT_ONE 6'h01
`define SFCD_CNT_OPT 6'h20
`define SFCD_CNT_MAX 6'h3f

// reset values
`define SFCD_CMD_RST 32'h0000_0000
`define SFCD_HW_RST 16'h0000

`endif

// file: include/sfcd_pkg.sv
// types shared by the serial frame command decoder
`include "sfcd_regs.svh"

package sfcd_pkg;

   // frame sequencer states
   typedef enum logic [2:0] {
      ST_ACQ   = 3'h1,
      ST_FRAME = 3'h2,
      ST_CONV  = 3'h4
   } sfcd_st_t;

   // read request pending for the next frame
   typedef enum logic [1:0] {
      RD_NONE = 2'h0,
      RD_HALF = 2'h1,
      RD_BYTE = 2'h2
   } sfcd_rd_t;

   // synchronised pin levels
   typedef struct packed {
      logic cs;
      logic sclk;
      logic sdi;
   } sfcd_pins_t;

   // complete module state
   typedef struct packed {
      sfcd_st_t st;
      logic rdy;
      logic drv;
      logic conv_start;
      logic cs_q;
      logic sclk_q;
      logic [`SFCD_CNT_W-1:0] cnt;
      logic [`SFCD_CMD_W-1:0] isr;
      logic [`SFCD_CMD_W-1:0] output_shift_register;
      logic [`SFCD_CMD_W-1:0] cmd;
      sfcd_rd_t rd_pend;
      logic [`SFCD_CMD_W-1:0] rd_word;
      logic [`SFCD_HW_COUNT-1:0][15:0] regs;
   } sfcd_state_t;

endpackage : sfcd_pkg

// file: hdl/sfcd_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ns

module sfcd_sync #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   // one pair of flops per bit; the first stage feeds only the second
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            meta_r[b] <= 1'b0;
            sync_r[b] <= 1'b0;
         end else begin
            meta_r[b] <= async_i[b];
            sync_r[b] <= meta_r[b];
         end
      end
   end

   assign sync_o = sync_r;

endmodule : sfcd_sync

// file: test/sfcd_frame_decoder_monitor.sv
// port checker for the serial frame command decoder
`timescale 1ns/1ns
`include "sfcd_regs.svh"

module sfcd_frame_decoder_monitor (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // serial pins
   input wire logic conversion_start_select_i,
   input wire logic sclk_i,
   // outputs and converter handshake
   input wire logic serial_output_lanes_o,
   input wire logic serial_output_lanes_oe_n_o,
   input wire logic ready_strobe_o,
   input wire logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic [`SFCD_HW_COUNT*16-1:0] reg_map_o,
   input wire logic [`SFCD_CMD_W-1:0] cmd_word_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   // pins pass two flops, so every reaction shows three edges after the pin moved
   a_frame_open: assert property ($fell(conversion_start_select_i) && ready_strobe_o |->
      ##3 !serial_output_lanes_oe_n_o && !ready_strobe_o) else $error("frame did not open");
   a_frame_close: assert property ($rose(conversion_start_select_i) && !serial_output_lanes_oe_n_o |->
      ##3 serial_output_lanes_oe_n_o && conv_start_o) else $error("frame did not close");
   a_ready_cause: assert property ($rose(ready_strobe_o) |-> $past(conv_done_i))
      else $error("ready rose without conversion done");
   a_ready_hold: assert property (!ready_strobe_o && !conv_done_i |=> !ready_strobe_o)
      else $error("ready rose early");
   a_cmd_clear: assert property ($fell(serial_output_lanes_oe_n_o) |=> cmd_word_o == '0)
      else $error("command not cleared at frame open");
   a_map_frame: assert property (!serial_output_lanes_oe_n_o |-> $stable(reg_map_o))
      else $error("register map changed inside a frame");
   a_map_close: assert property ($changed(reg_map_o) |-> conv_start_o)
      else $error("register map changed away from frame close");
   a_lane_launch: assert property (!serial_output_lanes_oe_n_o && !$past(serial_output_lanes_oe_n_o) &&
      $changed(serial_output_lanes_o) |-> !$past(sclk_i, 3)) else $error("lane moved off a launch edge");
endmodule : sfcd_frame_decoder_monitor

bind sfcd_frame_decoder sfcd_frame_decoder_monitor i_sfcd_frame_decoder_monitor (.core_clk_i(core_clk_i),
   .resetn_i(resetn_i), .conversion_start_select_i(conversion_start_select_i), .sclk_i(sclk_i),
   .serial_output_lanes_o(serial_output_lanes_o), .serial_output_lanes_oe_n_o(serial_output_lanes_oe_n_o),
   .ready_strobe_o(ready_strobe_o), .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
   .reg_map_o(reg_map_o), .cmd_word_o(cmd_word_o));

// file: test/sfcd_host_model.sv
// host controller model: drives select, serial clock and data
`timescale 1ns/1ns

module sfcd_host_model (
   // frame request
   input wire logic go_i,
   input wire logic [63:0] word_i,
   input wire logic [6:0] nbits_i,
   // serial pins
   output logic cs_o,
   output logic sclk_o,
   output logic sdi_o,
   input wire logic lane_i,
   input wire logic ready_i,
   // result
   output logic [31:0] rx_o,
   output logic busy_o
);
   int i;

   // clock idles low, select idles high
   initial begin
      cs_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      rx_o = 32'h0;
      busy_o = 1'b0;
   end

   // one frame per request; every pin move lands on a core falling edge
   always @(posedge go_i) begin
      busy_o = 1'b1;
      rx_o = 32'h0;
      cs_o = 1'b0;
      #160;
      // last bits sent are the command; capture on rise
      for (i = int'(nbits_i) - 1; i >= 0; i--) begin
         sdi_o = word_i[i];
         #80 sclk_o = 1'b1;
         rx_o = {rx_o[30:0], lane_i};
         #80 sclk_o = 1'b0;
      end
      // released data line must not keep its last level
      #80 sdi_o = ~sdi_o;
      cs_o = 1'b1;
      // no new frame before ready rises
      i = 0;
      while (ready_i !== 1'b1 && i < 500) begin
         #20 i++;
      end
      busy_o = 1'b0;
   end
endmodule : sfcd_host_model

// file: test/sfcd_frame_decoder_test.sv
// self-checking bench for the serial frame command decoder
`timescale 1ns/1ns

module sfcd_frame_decoder_test;
   logic core_clk_i, resetn_i, cs, sclk, sdi, lane, oe_n, ready, conv_start, conv_done = 1'b0, fixed_en, go, busy;
   logic [15:0] result;
   logic [31:0] fixed_word, cmd_word, rx, m_rd;
   logic [255:0] reg_map;
   logic [63:0] word;
   logic [6:0] nbits;
   logic [15:0] m_reg [16];
   logic m_pend;
   int n_mismatch, checked, cyc, t;
   logic [31:0] cw [10] = '{32'hd005_a5c3, 32'hd206_1234, 32'hd407_5678, 32'hc804_0000, 32'h4807_0000,
                            32'hc004_00ff, 32'hc004_00ff, 32'hd820_ffff, 32'hd604_ffff, 32'h0};
   int cn [10] = '{32, 32, 32, 32, 40, 16, 32, 32, 32, 32};

   sfcd_frame_decoder i_sfcd_frame_decoder (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .conversion_start_select_i(cs), .sclk_i(sclk), .sdi_i(sdi), .serial_output_lanes_o(lane),
      .serial_output_lanes_oe_n_o(oe_n), .ready_strobe_o(ready), .conv_start_o(conv_start),
      .conv_done_i(conv_done), .conv_result_i(result), .fixed_pattern_en_i(fixed_en),
      .fixed_pattern_i(fixed_word), .cmd_word_o(cmd_word), .reg_map_o(reg_map));
   sfcd_host_model i_sfcd_host_model (.go_i(go), .word_i(word), .nbits_i(nbits), .cs_o(cs), .sclk_o(sclk),
      .sdi_o(sdi), .lane_i(oe_n ? 1'bz : lane), .ready_i(ready), .rx_o(rx), .busy_o(busy));

   // clock
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   // converter core answers each start after a random delay
   always @(posedge core_clk_i) begin
      if (conv_start === 1'b1) begin
         repeat (2 + $urandom % 30) @(negedge core_clk_i);
         conv_done <= 1'b1;
         @(negedge core_clk_i);
         conv_done <= 1'b0;
      end
   end

   // hang guard, well above the expected run
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_map();
      logic [255:0] e;
      for (int k = 0; k < 16; k++) e[k*16 +: 16] = m_reg[k];
      checked++;
      if (reg_map !== e) begin
         n_mismatch++;
         $display("ERROR register map expected %h seen %h", e, reg_map);
      end
   endtask : chk_map

   // short frames show the leading bits, long ones shift zeros in behind the word
   function automatic logic [31:0] exp_rx(input logic [31:0] o, input int n);
      logic [63:0] s;
      if (n < 32) return o >> (32 - n);
      s = {o, 32'h0} << (n - 32);
      return s[63:32];
   endfunction : exp_rx

   function automatic logic [31:0] rand_cmd();
      logic [4:0] ops [5] = '{5'h18, 5'h19, 5'h1a, 5'h1b, 5'h09};
      logic [4:0] op;
      op = ops[$urandom % 5];
      return {op, 2'($urandom), 4'h0, 5'($urandom), (op[3:0] == 4'h9 && $urandom % 2) ? 16'h0 : 16'($urandom)};
   endfunction : rand_cmd

   // run one frame, then update the model and compare
   task automatic frame(input logic [31:0] cmd, input int n);
      logic [31:0] o;
      logic [15:0] h;
      int k;
      result = 16'($urandom);
      // fixed pattern, then pending read, then conversion result
      o = fixed_en ? fixed_word : m_pend ? m_rd : {result, 16'h0};
      m_pend = 1'b0;
      word = {32'($urandom), cmd};
      nbits = 7'(n);
      go = 1'b1;
      @(negedge core_clk_i);
      go = 1'b0;
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge core_clk_i);
      chk_word("serial out", exp_rx(o, n), rx);
      k = int'(cmd[20:17]);
      h = m_reg[k];
      // effects of full or long frames in range
      if (n >= 32 && cmd[24:21] == 4'h0) begin
         case (cmd[31:27])
            5'h18: m_reg[k] = h & ~cmd[15:0];
            5'h1b: m_reg[k] = h | cmd[15:0];
            5'h1a: if (cmd[26:25] != 2'h3) m_reg[k] = {cmd[26:25] == 2'h2 ? h[15:8] : cmd[15:8],
                                                        cmd[26:25] == 2'h1 ? h[7:0] : cmd[7:0]};
            5'h19: if (cmd[15:0] == 16'h0) {m_pend, m_rd} = {1'b1, h, 16'h0};
            5'h09: if (cmd[15:0] == 16'h0) {m_pend, m_rd} = {1'b1, cmd[16] ? h[15:8] : h[7:0], 24'h0};
            default: ;
         endcase
      end
      chk_word("command", n >= 32 ? cmd : 32'h0, cmd_word);
      chk_map();
   endtask : frame

   task automatic print_verdict();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // main sequence
   initial begin
      resetn_i = 1'b0;
      {go, fixed_en, result, word, nbits, m_pend, m_rd} = '0;
      t = $urandom(32'h8138);
      fixed_word = $urandom;
      foreach (m_reg[k]) m_reg[k] = 16'h0;
      repeat (16) @(negedge core_clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      chk_word("ready", 32'h1, {31'h0, ready});
      chk_word("command", 32'h0, cmd_word);
      chk_map();
      $display("reset values done");
      for (t = 0; t < 24; t++) frame(rand_cmd(), 28 + $urandom % 13);
      $display("random frames done");
      for (t = 0; t < 10; t++) begin
         fixed_en = (t == 0);
         frame(cw[t], cn[t]);
      end
      $display("corner frames done");
      print_verdict();
   end
endmodule : sfcd_frame_decoder_test
